// ---- design/ddr_cmd_defs.svh ----
// Command decoder constants: bit positions, counts, resets.
// Assumes includers use the macros by name; no logic here.
// Behaviour
// R1 - Command word bit 47 set means read, clear means write.
// R2 - Bit 46 clear targets memory array, set targets register space.
// R3 - Bit 45 clear requests wrapped burst, set requests linear burst.
// R4 - Bits 44 to 16 form word address bits 31 to 3.
// R5 - Master zeroes upper row bits beyond the device density.
// R6 - Bits 15 to 3 are reserved and ignored by the device.
// R7 - Bits 2 to 0 give the starting word within the half-page.
// R8 - Upper column picks an aligned eight-word half-page.
// R9 - Internal pages are sixteen words; page crossing may add strobe latency.
// R10 - Row crossing may add strobe latency, device dependent.
// R11 - Initial read latency counts from capture of the upper address bits; the decoder starts its count on the clock after the third command cycle.
// R12 - Linear read bursts run on continuously across half-pages.
// R13 - Each address selects one sixteen-bit word of two bytes.
// R14 - On reads the device drives the strobe edge-aligned with data.
// R15 - Transfers are whole sixteen-bit words only.
// R16 - Address advances each cycle; first byte strobe high, second strobe low.
// R17 - Byte bit 7 on data line 7, bit 0 on line 0.
// R18 - Select low with idle clock starts; three cycles carry six command bytes.
// R19 - Most significant command byte, bits 47 to 40, comes first.
// R20 - During command phase strobe high means extra latency, low means none.
// R21 - Master drives strobe as write data mask during write data.
// R22 - Select rising before six bytes discards the command, no access.
`ifndef DDR_CMD_DEFS_SVH
`define DDR_CMD_DEFS_SVH

`define CMD_READ_BIT     47
`define CMD_SPACE_BIT    46
`define CMD_BURST_BIT    45
`define CMD_UPPER_HI     44
`define CMD_UPPER_LO     16
`define CMD_LOWER_HI     2
`define CMD_LOWER_LO     0
`define CMD_WORD_BITS    48
`define CMD_CYCLES       2'h3
`define HALF_PAGE_BITS   3
`define INIT_LATENCY     6
`define LAT_WIDTH        8
`define BYTE_RESET       8'h00
`define WORD_RESET       16'h0000

`endif

// ---- design/ddr_cmd_pkg.sv ----
// Types shared by the decoder files.
// Assumes ddr_cmd_defs.svh is on the include path.
`include "ddr_cmd_defs.svh"

package ddr_cmd_pkg;

    // Decoded command word
    typedef struct packed {
        logic                                   is_read;
        logic                                   space_select_bit;
        logic                                   linear;
        logic [`CMD_UPPER_HI-`CMD_UPPER_LO:0]   upper;
        logic [`CMD_LOWER_HI:0]                 lower;
    } cmd_fields_type;

    // Write word for the core; mask bit high = byte not written
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] data;
        logic [1:0]  mask;
    } wr_word_type;

    // Link-side frame phases
    typedef enum logic [3:0] {
        PH_IDLE    = 4'b0001,
        PH_CMD     = 4'b0010,
        PH_LATENCY = 4'b0100,
        PH_DATA    = 4'b1000
    } phase_type;

endpackage : ddr_cmd_pkg

// ---- design/toggle_event_sync.sv ----
// Turns a toggle from another clock domain into a one-cycle pulse.
// Assumes the toggle flips at most once per three cycles.
`timescale 1ns/1ps

module toggle_event_sync (
    // Clock and control
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // Event
    input  wire logic toggle_in,
    output logic      pulse_out
);

    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       pulse_next;

    // First stage feeds only the second; edge seen between stages two and three
    always_comb begin
        sync_next  = {sync_reg[1:0], toggle_in};
        pulse_next = sync_reg[1] ^ sync_reg[2];
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync_reg  <= 3'h0;
            pulse_out <= 1'b0;
        end else if (ce_in) begin
            sync_reg  <= sync_next;
            pulse_out <= pulse_next;
        end
    end

endmodule // toggle_event_sync

// ---- design/ddr_command_address_decoder.sv ----
// Device end of an 8-bit DDR memory link: command capture, data placement.
// Assumes link_clk_in also runs with select high (in reset, before frames) and select rises between frames.
`timescale 1ns/1ps
`include "ddr_cmd_defs.svh"

module ddr_command_address_decoder #(
    parameter int INIT_LAT = `INIT_LATENCY
) (
    // Core clock and control
    input  wire logic                        mclk_in,
    input  wire logic                        rst_in,
    input  wire logic                        ce_in,
    input  wire logic                        latency_req_in,
    input  wire logic [15:0]                 rd_word_in,
    // Link pins
    input  wire logic                        link_clk_in,
    input  wire logic                        select_n_in,
    input  wire logic [7:0]                  dq_in,
    output logic      [7:0]                  dq_out,
    output logic                             dq_oe_out,
    input  wire logic                        strobe_in,
    output logic                             strobe_out,
    output logic                             strobe_oe_out,
    // Decoded command and write words
    output ddr_cmd_pkg::cmd_fields_type      cmd_out,
    output logic                             cmd_valid_out,
    output ddr_cmd_pkg::wr_word_type         wr_out,
    output logic                             wr_valid_out
);

    if (INIT_LAT < 1 || 2 * INIT_LAT > 255) begin : g_lat_check
        $error("INIT_LAT out of range for the latency counter");
    end

    // Split a command word into fields; reserved bits unread
    function automatic ddr_cmd_pkg::cmd_fields_type decode_cmd(
        input logic [`CMD_WORD_BITS-1:0] word
    );
        ddr_cmd_pkg::cmd_fields_type f;
        // R1 read or write
        f.is_read          = word[`CMD_READ_BIT];
        // R2 space select
        f.space_select_bit = word[`CMD_SPACE_BIT];
        // R3 burst type
        f.linear           = word[`CMD_BURST_BIT];
        // R4 upper address
        f.upper            = word[`CMD_UPPER_HI:`CMD_UPPER_LO];
        // R7 lower column, R6 reserved bits dropped
        f.lower            = word[`CMD_LOWER_HI:`CMD_LOWER_LO];
        return f;
    endfunction

    // R9 R10 next address; no crossing latency added
    function automatic logic [31:0] next_addr(input logic [31:0] addr, input logic linear);
        logic [31:0] n;
        n = addr + 32'h0000_0001;
        // R8 wrap in half-page
        if (!linear) begin
            n = {addr[31:`HALF_PAGE_BITS], n[`HALF_PAGE_BITS-1:0]};
        end
        return n;
    endfunction

    // Link-side reset and level synchronisers
    logic        lrst_s1_reg;
    logic        lrst_reg;
    logic        lat_s1_reg;
    logic        lat_sync_reg;
    logic [15:0] rd_s1_reg;
    logic [15:0] rd_sync_reg;

    always_ff @(posedge link_clk_in) begin
        lrst_s1_reg  <= rst_in;
        lrst_reg     <= lrst_s1_reg;
        lat_s1_reg   <= latency_req_in;
        lat_sync_reg <= lat_s1_reg;
        rd_s1_reg    <= rd_word_in;
        rd_sync_reg  <= rd_s1_reg;
    end

    // Rising-edge frame state, cleared at once when select rises
    ddr_cmd_pkg::phase_type phase_reg, phase_next;
    logic [1:0]             cyc_reg, cyc_next;
    logic [23:0]            rise_sh_reg, rise_sh_next;
    logic [31:0]            addr_reg, addr_next;
    logic                   is_read_reg, is_read_next;
    logic                   linear_reg, linear_next;
    logic [`LAT_WIDTH-1:0]  lat_cnt_reg, lat_cnt_next;
    logic [15:0]            word_reg, word_next;
    logic [7:0]             a_byte_reg, a_byte_next;
    logic                   a_mask_reg, a_mask_next;
    logic                   a_valid_reg, a_valid_next;
    logic [31:0]            wcap_addr_reg, wcap_addr_next;
    logic [7:0]             p_dq_reg, p_dq_next;
    logic                   p_s_reg, p_s_next;
    logic                   dq_oe_reg, dq_oe_next;
    logic                   s_oe_reg, s_oe_next;

    // Falling-edge frame state
    logic [1:0]             ncyc_reg, ncyc_next;
    logic [23:0]            fall_sh_reg, fall_sh_next;
    logic [7:0]             n_dq_reg, n_dq_next;
    logic                   n_s_reg, n_s_next;

    // Assembled word and its fields
    logic [`CMD_WORD_BITS-1:0]   cmd_word;
    ddr_cmd_pkg::cmd_fields_type fields;
    logic                        cmd_done;
    logic [`LAT_WIDTH-1:0]       lat_total;

    // R19 first byte is bits 47 to 40; rising bytes even, falling bytes odd
    assign cmd_word  = {rise_sh_reg[23:16], fall_sh_reg[23:16], rise_sh_reg[15:8],
                        fall_sh_reg[15:8], rise_sh_reg[7:0], fall_sh_reg[7:0]};
    assign fields    = decode_cmd(cmd_word);
    assign cmd_done  = (phase_reg == ddr_cmd_pkg::PH_CMD) && (cyc_reg == `CMD_CYCLES);
    assign lat_total = lat_sync_reg ? `LAT_WIDTH'(2 * INIT_LAT) : `LAT_WIDTH'(INIT_LAT);

    // Rising-edge next state: capture, latency count, read byte A
    always_comb begin
        phase_next     = phase_reg;
        cyc_next       = cyc_reg;
        rise_sh_next   = rise_sh_reg;
        addr_next      = addr_reg;
        is_read_next   = is_read_reg;
        linear_next    = linear_reg;
        lat_cnt_next   = lat_cnt_reg;
        word_next      = word_reg;
        a_byte_next    = a_byte_reg;
        a_mask_next    = a_mask_reg;
        a_valid_next   = a_valid_reg;
        wcap_addr_next = wcap_addr_reg;
        p_dq_next      = p_dq_reg;
        p_s_next       = p_s_reg;
        dq_oe_next     = dq_oe_reg;
        s_oe_next      = s_oe_reg;
        unique case (phase_reg)
            // R18 first rising edge after select low
            ddr_cmd_pkg::PH_IDLE: begin
                rise_sh_next = {rise_sh_reg[15:0], dq_in};
                cyc_next     = 2'h1;
                phase_next   = ddr_cmd_pkg::PH_CMD;
                s_oe_next    = 1'b1;
                // R20 latency level
                p_s_next     = lat_sync_reg ^ n_s_reg;
            end
            ddr_cmd_pkg::PH_CMD: begin
                p_s_next = lat_sync_reg ^ n_s_reg;
                if (!cmd_done) begin
                    // R17 lines map straight to bits
                    rise_sh_next = {rise_sh_reg[15:0], dq_in};
                    cyc_next     = cyc_reg + 2'h1;
                end else begin
                    // R11 latency starts once address is held
                    addr_next    = {fields.upper, fields.lower};
                    is_read_next = fields.is_read;
                    linear_next  = fields.linear;
                    lat_cnt_next = lat_total - `LAT_WIDTH'(1);
                    phase_next   = ddr_cmd_pkg::PH_LATENCY;
                    // R21 master owns the strobe on writes
                    s_oe_next    = fields.is_read;
                end
            end
            ddr_cmd_pkg::PH_LATENCY: begin
                if (lat_cnt_reg != `LAT_WIDTH'(0)) begin
                    lat_cnt_next = lat_cnt_reg - `LAT_WIDTH'(1);
                end else begin
                    phase_next = ddr_cmd_pkg::PH_DATA;
                    if (is_read_reg) begin
                        // R14 strobe rises with byte A
                        word_next  = rd_sync_reg;
                        p_dq_next  = rd_sync_reg[15:8] ^ n_dq_reg;
                        p_s_next   = 1'b1 ^ n_s_reg;
                        dq_oe_next = 1'b1;
                    end
                end
            end
            ddr_cmd_pkg::PH_DATA: begin
                // R16 one word per cycle
                addr_next = next_addr(addr_reg, linear_reg);
                if (is_read_reg) begin
                    // R12 linear reads keep going across half-pages
                    word_next = rd_sync_reg;
                    p_dq_next = rd_sync_reg[15:8] ^ n_dq_reg;
                    p_s_next  = 1'b1 ^ n_s_reg;
                end else begin
                    // R15 byte A held until its byte B arrives
                    a_byte_next    = dq_in;
                    a_mask_next    = strobe_in;
                    a_valid_next   = 1'b1;
                    wcap_addr_next = addr_reg;
                end
            end
        endcase
    end

    always_ff @(posedge link_clk_in or posedge select_n_in) begin
        // R22 select high drops any partial command
        if (select_n_in) begin
            phase_reg     <= ddr_cmd_pkg::PH_IDLE;
            cyc_reg       <= 2'h0;
            rise_sh_reg   <= 24'h00_0000;
            addr_reg      <= 32'h0000_0000;
            is_read_reg   <= 1'b0;
            linear_reg    <= 1'b0;
            lat_cnt_reg   <= `LAT_WIDTH'(0);
            word_reg      <= `WORD_RESET;
            a_byte_reg    <= `BYTE_RESET;
            a_mask_reg    <= 1'b0;
            a_valid_reg   <= 1'b0;
            wcap_addr_reg <= 32'h0000_0000;
            p_dq_reg      <= `BYTE_RESET;
            p_s_reg       <= 1'b0;
            dq_oe_reg     <= 1'b0;
            s_oe_reg      <= 1'b0;
        end else begin
            phase_reg     <= phase_next;
            cyc_reg       <= cyc_next;
            rise_sh_reg   <= rise_sh_next;
            addr_reg      <= addr_next;
            is_read_reg   <= is_read_next;
            linear_reg    <= linear_next;
            lat_cnt_reg   <= lat_cnt_next;
            word_reg      <= word_next;
            a_byte_reg    <= a_byte_next;
            a_mask_reg    <= a_mask_next;
            a_valid_reg   <= a_valid_next;
            wcap_addr_reg <= wcap_addr_next;
            p_dq_reg      <= p_dq_next;
            p_s_reg       <= p_s_next;
            dq_oe_reg     <= dq_oe_next;
            s_oe_reg      <= s_oe_next;
        end
    end

    // Falling-edge next state: odd command bytes, read byte B
    always_comb begin
        ncyc_next    = ncyc_reg;
        fall_sh_next = fall_sh_reg;
        n_dq_next    = n_dq_reg;
        n_s_next     = n_s_reg;
        if (phase_reg == ddr_cmd_pkg::PH_CMD && ncyc_reg != `CMD_CYCLES) begin
            fall_sh_next = {fall_sh_reg[15:0], dq_in};
            ncyc_next    = ncyc_reg + 2'h1;
        end
        // R16 strobe falls with byte B
        if (phase_reg == ddr_cmd_pkg::PH_DATA && is_read_reg) begin
            n_dq_next = word_reg[7:0] ^ p_dq_reg;
            n_s_next  = p_s_reg;
        end
    end

    always_ff @(negedge link_clk_in or posedge select_n_in) begin
        if (select_n_in) begin
            ncyc_reg    <= 2'h0;
            fall_sh_reg <= 24'h00_0000;
            n_dq_reg    <= `BYTE_RESET;
            n_s_reg     <= 1'b0;
        end else begin
            ncyc_reg    <= ncyc_next;
            fall_sh_reg <= fall_sh_next;
            n_dq_reg    <= n_dq_next;
            n_s_reg     <= n_s_next;
        end
    end

    // Pins: the two edge registers combine so each half-cycle shows its own byte
    assign dq_out        = p_dq_reg ^ n_dq_reg;
    assign strobe_out    = p_s_reg ^ n_s_reg;
    assign dq_oe_out     = dq_oe_reg;
    assign strobe_oe_out = s_oe_reg;

    // Command hand-over: held fields plus a toggle, survives select going high
    ddr_cmd_pkg::cmd_fields_type cmd_hold_reg, cmd_hold_next;
    logic                        cmd_tgl_reg, cmd_tgl_next;

    always_comb begin
        cmd_hold_next = cmd_hold_reg;
        cmd_tgl_next  = cmd_tgl_reg;
        if (cmd_done) begin
            cmd_hold_next = fields;
            cmd_tgl_next  = ~cmd_tgl_reg;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (lrst_reg) begin
            cmd_hold_reg <= '0;
            cmd_tgl_reg  <= 1'b0;
        end else begin
            cmd_hold_reg <= cmd_hold_next;
            cmd_tgl_reg  <= cmd_tgl_next;
        end
    end

    // Write hand-over: two slots so a word stays still while the core copies it
    ddr_cmd_pkg::wr_word_type wr_slot_reg [2];
    ddr_cmd_pkg::wr_word_type wr_slot_next [2];
    logic                     wr_tgl_reg, wr_tgl_next;

    always_comb begin
        wr_slot_next = wr_slot_reg;
        wr_tgl_next  = wr_tgl_reg;
        // R13 one address per two-byte word
        if (phase_reg == ddr_cmd_pkg::PH_DATA && !is_read_reg && a_valid_reg) begin
            wr_slot_next[~wr_tgl_reg] = {wcap_addr_reg, a_byte_reg, dq_in, a_mask_reg, strobe_in};
            wr_tgl_next               = ~wr_tgl_reg;
        end
    end

    always_ff @(negedge link_clk_in) begin
        if (lrst_reg) begin
            wr_slot_reg[0] <= '0;
            wr_slot_reg[1] <= '0;
            wr_tgl_reg     <= 1'b0;
        end else begin
            wr_slot_reg <= wr_slot_next;
            wr_tgl_reg  <= wr_tgl_next;
        end
    end

    // Core-side event detection
    logic cmd_pulse;
    logic wr_pulse;

    toggle_event_sync u_cmd_sync (
        .clk_in    (mclk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .toggle_in (cmd_tgl_reg),
        .pulse_out (cmd_pulse)
    );

    toggle_event_sync u_wr_sync (
        .clk_in    (mclk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .toggle_in (wr_tgl_reg),
        .pulse_out (wr_pulse)
    );

    // Core outputs; held link data is stable by the pulse
    ddr_cmd_pkg::cmd_fields_type cmd_next;
    ddr_cmd_pkg::wr_word_type    wr_next;
    logic                        rd_sel_reg, rd_sel_next;

    always_comb begin
        cmd_next    = cmd_out;
        wr_next     = wr_out;
        rd_sel_next = rd_sel_reg;
        if (cmd_pulse) begin
            cmd_next = cmd_hold_reg;
        end
        if (wr_pulse) begin
            rd_sel_next = ~rd_sel_reg;
            wr_next     = wr_slot_reg[~rd_sel_reg];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cmd_out       <= '0;
            cmd_valid_out <= 1'b0;
            wr_out        <= '0;
            wr_valid_out  <= 1'b0;
            rd_sel_reg    <= 1'b0;
        end else if (ce_in) begin
            cmd_out       <= cmd_next;
            cmd_valid_out <= cmd_pulse;
            wr_out        <= wr_next;
            wr_valid_out  <= wr_pulse;
            rd_sel_reg    <= rd_sel_next;
        end
    end

endmodule // ddr_command_address_decoder

// ---- bench/ddr_cad_checker_assertions.sv ----
// Port-level checks of the decoder.
// Assumes binding into the decoder.
`timescale 1ns/1ps

module ddr_cad_checker (
    // Clocks and select
    input wire logic                         mclk_in,
    input wire logic                         rst_in,
    input wire logic                         link_clk_in,
    input wire logic                         select_n_in,
    // Watched outputs
    input wire logic                         dq_oe_out,
    input wire logic                         strobe_out,
    input wire logic                         strobe_oe_out,
    input wire ddr_cmd_pkg::cmd_fields_type  cmd_out,
    input wire logic                         cmd_valid_out,
    input wire ddr_cmd_pkg::wr_word_type     wr_out,
    input wire logic                         wr_valid_out
);
    logic        first_reg;
    logic [31:0] prev_reg;
    wire  [31:0] start_addr = {cmd_out.upper, cmd_out.lower};

    // First write word follows each decode
    always_ff @(posedge mclk_in) begin
        first_reg <= (rst_in || cmd_valid_out) ? 1'b1 : (wr_valid_out ? 1'b0 : first_reg);
        prev_reg  <= wr_valid_out ? wr_out.addr : prev_reg;
    end

    a_cmd_pulse_once: assert property (@(posedge mclk_in) disable iff (rst_in)
        cmd_valid_out |=> !cmd_valid_out) else $error("cmd pulse long");
    a_wr_pulse_once: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_valid_out |=> !wr_valid_out) else $error("wr pulse long");
    a_cmd_held_still: assert property (@(posedge mclk_in) disable iff (rst_in)
        !cmd_valid_out |-> $stable(cmd_out)) else $error("cmd_out moved");
    a_wr_only_writes: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_valid_out |-> !cmd_out.is_read) else $error("write word in read frame");
    a_first_wr_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_valid_out && first_reg |-> wr_out.addr == start_addr) else $error("bad start addr");
    a_wr_addr_step: assert property (@(posedge mclk_in) disable iff (rst_in)
        wr_valid_out && !first_reg |-> wr_out.addr == (cmd_out.linear ? prev_reg + 32'h1 :
        {prev_reg[31:3], prev_reg[2:0] + 3'h1})) else $error("bad address step");
    a_idle_released: assert property (@(posedge mclk_in) disable iff (rst_in)
        select_n_in && $past(select_n_in) |-> !dq_oe_out && !strobe_oe_out)
        else $error("pins driven");
    a_read_strobe_on: assert property (@(posedge mclk_in) disable iff (rst_in)
        dq_oe_out |-> strobe_oe_out) else $error("no read strobe");
    // byte A in strobe high phase
    a_byte_a_high: assert property (@(negedge link_clk_in) disable iff (rst_in || select_n_in)
        dq_oe_out |-> strobe_out) else $error("strobe low in byte A");
    // byte B in strobe low phase
    a_byte_b_low: assert property (@(posedge link_clk_in) disable iff (rst_in || select_n_in)
        dq_oe_out |-> !strobe_out) else $error("strobe high in byte B");

    c_read_burst: cover property (@(negedge link_clk_in) dq_oe_out);
    c_write_next: cover property (@(posedge mclk_in) wr_valid_out && !first_reg);
    c_reg_space: cover property (@(posedge mclk_in) cmd_valid_out && cmd_out.space_select_bit);
endmodule // ddr_cad_checker

bind ddr_command_address_decoder ddr_cad_checker u_chk (.mclk_in, .rst_in, .link_clk_in,
    .select_n_in, .dq_oe_out, .strobe_out, .strobe_oe_out, .cmd_out, .cmd_valid_out,
    .wr_out, .wr_valid_out);

// ---- bench/link_master_model.sv ----
// Link master: clock, select, command bytes, write data, masks.
// Assumes one task at a time; read bytes are kept for the bench.
`timescale 1ns/1ps

module link_master_model (
    // From the device
    input  wire logic [7:0] dq_out,
    input  wire logic       dq_oe_out,
    input  wire logic       strobe_out,
    input  wire logic       strobe_oe_out,
    // Toward the device
    output logic            link_clk_out,
    output logic            select_n_out,
    output logic [7:0]      dq_line_out,
    output logic            strobe_line_out
);
    logic [7:0] dq_reg    = 8'h00;
    logic       drive_reg = 1'b0;
    logic       mask_reg  = 1'b0;
    logic [8:0] rd_q[$];
    int         first_c;
    logic       lat_seen;

    initial begin
        link_clk_out = 1'b0;
        select_n_out = 1'b1;
    end

    // Released lines show the inverse
    assign dq_line_out     = dq_oe_out ? dq_out : (drive_reg ? dq_reg : ~dq_reg);
    assign strobe_line_out = strobe_oe_out ? strobe_out : (drive_reg ? mask_reg : ~mask_reg);

    // Clock with select high so synchronisers settle
    task automatic idle(input int n);
        repeat (2 * n) #80 link_clk_out = ~link_clk_out;
    endtask

    // nb command bytes, nc data cycles; write data from cycle lat+1
    task automatic frame(input logic [47:0] ca, input int nb, input int lat, input int nc,
                         input logic [15:0] wbase, input logic [1:0] wmask);
        logic [15:0] w;
        int          k;
        rd_q.delete();
        first_c = -1;
        select_n_out = 1'b0;
        drive_reg = 1'b1;
        // MSB byte first, bit 7 on line 7
        for (int e = 0; e < nb; e++) begin
            dq_reg = ca[47 - 8 * e -: 8];
            #40 link_clk_out = ~link_clk_out;
            #40 if (e == 1) lat_seen = strobe_line_out;
        end
        for (int c = 0; c < nc && nb == 6; c++) begin
            k = c - lat - 1;
            w = wbase + k[15:0];
            drive_reg = !ca[47];
            for (int h = 0; h < 2; h++) begin
                dq_reg = h ? w[7:0] : w[15:8];
                mask_reg = (k >= 0) && wmask[1 - h] && k[0];
                #40 link_clk_out = ~link_clk_out;
                #40 if (dq_oe_out) begin
                    if (first_c < 0) first_c = c;
                    rd_q.push_back({strobe_line_out, dq_line_out});
                end
            end
        end
        #40 select_n_out = 1'b1;
        drive_reg = 1'b0;
    endtask
endmodule // link_master_model

// ---- bench/ddr_command_address_decoder_tb.sv ----
// Decoder bench: all command kinds, both latencies, an abort.
// Assumes the master model drives the link; checker is bound.
`timescale 1ns/1ps

module ddr_command_address_decoder_tb;
    localparam int LAT = 3;
    logic        mclk_in        = 1'b0;
    logic        rst_in         = 1'b1;
    logic        ce_in          = 1'b1;
    logic        latency_req_in = 1'b0;
    logic [15:0] rd_word_in     = 16'h0000;
    wire         link_clk, select_n, strobe_line, dq_oe, strobe, strobe_oe;
    wire  [7:0]  dq_line, dq;
    logic [34:0] cmd;
    logic [49:0] wr;
    logic        cmd_v, wr_v;
    logic [49:0] wr_q[$];
    int          failures = 0;
    int          compares = 0;
    int          cmd_count = 0;

    // 25 MHz core clock
    always #20 mclk_in = ~mclk_in;

    ddr_command_address_decoder #(.INIT_LAT(LAT)) dut (.mclk_in, .rst_in, .ce_in,
        .latency_req_in, .rd_word_in,
        .link_clk_in(link_clk), .select_n_in(select_n), .dq_in(dq_line), .dq_out(dq),
        .dq_oe_out(dq_oe), .strobe_in(strobe_line), .strobe_out(strobe),
        .strobe_oe_out(strobe_oe), .cmd_out(cmd), .cmd_valid_out(cmd_v), .wr_out(wr),
        .wr_valid_out(wr_v));

    link_master_model master (.dq_out(dq), .dq_oe_out(dq_oe), .strobe_out(strobe),
        .strobe_oe_out(strobe_oe), .link_clk_out(link_clk), .select_n_out(select_n),
        .dq_line_out(dq_line), .strobe_line_out(strobe_line));

    // Count decodes, collect write words
    always @(posedge mclk_in) begin
        if (cmd_v === 1'b1) cmd_count++;
        if (wr_v === 1'b1) wr_q.push_back(wr);
    end

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic t_abort();
        int n0;
        n0 = cmd_count;
        master.frame(48'hC00000000005, 4, LAT, 0, 16'h0000, 2'b00);
        repeat (8) @(posedge mclk_in);
        chk("abort decode", n0, cmd_count);
        chk("abort released", 2'b00, {dq_oe, strobe_oe});
    endtask

    task automatic run_kind(input logic [2:0] m, input logic lreq);
        logic [47:0] ca;
        logic [31:0] a;
        int          n0;
        int          lat;
        ca = {m, 29'h0ABCDEF1, 13'h1FFF, 3'h6};
        lat = lreq ? 2 * LAT : LAT;
        n0 = cmd_count;
        wr_q.delete();
        @(posedge mclk_in);
        latency_req_in <= lreq;
        rd_word_in <= {5'h15, m, 8'h3C};
        master.idle(3);
        master.frame(ca, 6, lat, lat + 4, 16'h7E80, 2'b10);
        repeat (8) @(posedge mclk_in);
        chk("decode count", n0 + 1, cmd_count);
        chk("cmd fields", {m, 29'h0ABCDEF1, 3'h6}, cmd);
        chk("cmd phase strobe", lreq, master.lat_seen);
        if (m[2]) begin
            chk("first data cycle", lat, master.first_c);
            chk("read byte count", 8, master.rd_q.size());
            foreach (master.rd_q[i]) begin
                chk("read byte", i[0] ? {1'b0, rd_word_in[7:0]} : {1'b1, rd_word_in[15:8]},
                    master.rd_q[i]);
            end
        end else begin
            chk("write word count", 3, wr_q.size());
            foreach (wr_q[i]) begin
                a = {29'h0ABCDEF1, 3'h6} + i;
                if (!m[0]) a[31:3] = 29'h0ABCDEF1;
                chk("write word", {a, 16'h7E80 + i[15:0], i[0] ? 2'b10 : 2'b00},
                    wr_q[i]);
            end
        end
    endtask

    // Link clock runs in reset so its flops clear
    initial begin
        master.idle(4);
        @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        chk("reset pulses", 2'b00, {cmd_v, wr_v});
        master.idle(3);
        t_abort();
        for (int m = 0; m < 8; m++) begin
            run_kind(m[2:0], m[1]);
        end
        close_out();
    end

    // About 24 us of frames; a twelvefold margin cuts a hang
    initial begin
        #300000;
        failures++;
        close_out();
    end
endmodule // ddr_command_address_decoder_tb
